// file: verilog/olsc_startup_cfg.sv
// APB slave holding the open-loop startup configuration register and its decoded controls.
//
// Behaviour
// R1: 32-bit register at offset 0x84; bit 31 parity, read/write.
// R2: Bit 30 picks open-loop threshold field (0) or general limit (1).
// R3: Bits 29-27 cap open-loop duty: 10,15,20,25,30,40,50,100 percent.
// R4: Bits 26-23 threshold code; 0 reserved, 1-15 mean 0.1-1.5 V.
// R5: Bits 22-18 first-order acceleration, codes 0-1Eh from 0.005 to 1000 Hz/s; the code decodes 0 as zero and saturates 1Dh and 1Eh at FFFFh.
// R6: First-order code 1Fh means no limit, applied as 32767 Hz/s; the code sets accel1_unlimited and saturates accel1_centi_hz_s at FFFFh.
// R7: Writable fields reset to zero; bits 1-0 reserved read-only.
// R8: Bits 17-13 second-order acceleration, 1Fh means no limit.
// R9: Bits 12-8 handoff frequency code, 1 Hz up to 600 Hz.
// R10: Bit 7 auto handoff; bit 6 forces first-cycle frequency zero.
// R11: Writes to reserved bits are ignored, other fields unaffected.
//
// Implementation choice: the APB register port.

`include "olsc_consts.svh"
`default_nettype none
module olsc_startup_cfg #(
  // Address width; the register offset must fit and the bus is at most a word wide.
  parameter int ADDR_W = `OLSC_ADDR_W
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output olsc_pkg::olsc_cfg_t cfg,
  output olsc_pkg::olsc_ctrl_t ctrl
);

  // Register storage and its next value.
  logic [31:0] cfg_reg;
  logic [31:0] cfg_next;
  // Bus answer flops; they change together so a master never sees them skewed.
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  // Transfer phase: idle, or answering the access just taken.
  olsc_pkg::olsc_state_t state_reg;
  olsc_pkg::olsc_ctrl_t ctrl_reg;
  olsc_pkg::olsc_ctrl_t ctrl_next;
  // Address and write decode helpers.
  logic hit;
  logic wr_hit;
  logic [31:0] byte_mask;

  // Refuse an address width that cannot hold the register offset: the byte
  // address 0x84 needs eight bits, and a bus wider than a word is not served.
  if (ADDR_W < 8 || ADDR_W > 32)
  begin : g_bad_addr_w
    $error("olsc_startup_cfg: ADDR_W out of range");
  end

  // Duty cap in percent for a 3-bit code.
  // Code 7 jumps to full duty, which in effect removes the cap.
  function automatic logic [6:0] duty_pct(input logic [2:0] code);
    unique case (code)
      3'h0: duty_pct = 7'h0a;
      3'h1: duty_pct = 7'h0f;
      3'h2: duty_pct = 7'h14;
      3'h3: duty_pct = 7'h19;
      3'h4: duty_pct = 7'h1e;
      3'h5: duty_pct = 7'h28;
      3'h6: duty_pct = 7'h32;
      3'h7: duty_pct = 7'h64;
    endcase
  endfunction : duty_pct

  // Acceleration in hundredths of Hz/s; sub-hundredth steps round to zero,
  // and the unlimited code saturates the field at its ceiling.
  // Codes 1Dh and 1Eh saturate as well, since their rates do not fit in hundredths;
  // a user needing the unlimited case must look at accel1_unlimited instead.
  function automatic logic [15:0] accel_centi(input logic [4:0] code);
    unique case (code)
      5'h00: accel_centi = 16'h0000;
      5'h01: accel_centi = 16'h0001;
      5'h02: accel_centi = 16'h0002;
      5'h03: accel_centi = 16'h0005;
      5'h04: accel_centi = 16'h000a;
      5'h05: accel_centi = 16'h0019;
      5'h06: accel_centi = 16'h0032;
      5'h07: accel_centi = 16'h0064;
      5'h08: accel_centi = 16'h00fa;
      5'h09: accel_centi = 16'h01f4;
      5'h0a: accel_centi = 16'h02ee;
      5'h0b: accel_centi = 16'h03e8;
      5'h0c: accel_centi = 16'h04e2;
      5'h0d: accel_centi = 16'h05dc;
      5'h0e: accel_centi = 16'h07d0;
      5'h0f: accel_centi = 16'h0bb8;
      5'h10: accel_centi = 16'h0fa0;
      5'h11: accel_centi = 16'h1388;
      5'h12: accel_centi = 16'h1770;
      5'h13: accel_centi = 16'h1d4c;
      5'h14: accel_centi = 16'h2710;
      5'h15: accel_centi = 16'h30d4;
      5'h16: accel_centi = 16'h3a98;
      5'h17: accel_centi = 16'h445c;
      5'h18: accel_centi = 16'h4e20;
      5'h19: accel_centi = 16'h61a8;
      5'h1a: accel_centi = 16'h7530;
      5'h1b: accel_centi = 16'h9c40;
      5'h1c: accel_centi = 16'hc350;
      5'h1d: accel_centi = 16'hffff;
      5'h1e: accel_centi = 16'hffff;
      5'h1f: accel_centi = 16'hffff;
    endcase
  endfunction : accel_centi

  // Handoff frequency in Hz for a 5-bit code.
  // Pure arithmetic in three linear pieces, so no table of 32 entries is needed.
  function automatic logic [9:0] handoff_hz(input logic [4:0] code);
    // Code 0 is the lone 1 Hz point below the linear pieces.
    if (code == 5'h00)
    begin
      handoff_hz = 10'h001;
    end
    // Codes 1 to 0Ah step by 4 Hz.
    else if (code <= 5'h0a)
    begin
      handoff_hz = {3'h0, code, 2'h0};
    end
    // Codes 0Bh to 14h step by 5 Hz from 45 Hz.
    else if (code <= 5'h14)
    begin
      handoff_hz = 10'(({5'h0, code} - 10'h00a) * 10'h005 + 10'h028);
    end
    // Codes 15h to 1Fh step by 50 Hz from 100 Hz.
    else
    begin
      handoff_hz = 10'(({5'h0, code} - 10'h015) * 10'h032 + 10'h064);
    end
  endfunction : handoff_hz

  // Only the one word decodes; any other address is answered with an error.
  assign hit = (paddr == ADDR_W'(`OLSC_OFF_CFG));

  // A write lands only at the edge where the master sees pready, so an access
  // that has not yet been answered cannot disturb the register.
  assign wr_hit = psel && penable && pwrite && hit && (state_reg == olsc_pkg::OLSC_ACCESS);

  // Byte strobes select which lanes of the word a write may touch.
  // A strobe of zero leaves the whole word alone.
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      byte_mask[i*8 +: 8] = {8{pstrb[i]}};
    end
  end

  // R11 reserved bits masked
  // Bits 1:0 lie outside the write mask, so no write can ever set them.
  always_comb
  begin
    cfg_next = cfg_reg;
    if (wr_hit)
    begin
      cfg_next = (cfg_reg & ~(byte_mask & `OLSC_WR_MASK)) | (pwdata & byte_mask & `OLSC_WR_MASK);
    end
  end

  // R1 register storage
  // R7 reset to zero
  // Asynchronous reset so the fields are defined before the first clock edge.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      cfg_reg <= `OLSC_RST_VAL;
    end
    else
    begin
      cfg_reg <= cfg_next;
    end
  end

  // Every access takes one wait state so pready comes from a flip-flop.
  // The trade is one extra cycle per access for a clean, registered answer.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= olsc_pkg::OLSC_IDLE;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end
    else
    begin
      unique case (state_reg)
        olsc_pkg::OLSC_IDLE:
        begin
          // The first access-phase edge is taken; the answer stands on the next.
          if (psel && penable)
          begin
            state_reg <= olsc_pkg::OLSC_ACCESS;
            pready_reg <= 1'b1;
            pslverr_reg <= !hit;
            // Refused and write accesses answer zero so stale data never leaks.
            // R7 reserved reads zero
            prdata_reg <= (hit && !pwrite) ?
              {cfg_reg[31:2], `OLSC_RSVD_READ} : 32'h0000_0000;
          end
        end
        olsc_pkg::OLSC_ACCESS:
        begin
          // The answer lasts one cycle; the master releases the bus at this edge.
          state_reg <= olsc_pkg::OLSC_IDLE;
          pready_reg <= 1'b0;
          pslverr_reg <= 1'b0;
        end
        default:
        begin
          // An illegal state code falls back to idle with no answer pending.
          state_reg <= olsc_pkg::OLSC_IDLE;
          pready_reg <= 1'b0;
          pslverr_reg <= 1'b0;
        end
      endcase
    end
  end

  // Decoded controls for the startup sequencer.
  // Decoding the next value keeps ctrl aligned with cfg on the same edge.
  always_comb
  begin
    // R2 limit source
    ctrl_next.limit_from_general = cfg_next[`OLSC_BIT_LIM_SRC];
    // R3 duty cap decode
    ctrl_next.duty_cap_pct = duty_pct(cfg_next[`OLSC_DUTY_HI:`OLSC_DUTY_LO]);
    // Amperes follow downstream from this voltage and the current sense gain.
    // R4 threshold code
    ctrl_next.threshold_tenths_v = cfg_next[`OLSC_THR_HI:`OLSC_THR_LO];
    ctrl_next.threshold_reserved =
      (cfg_next[`OLSC_THR_HI:`OLSC_THR_LO] == `OLSC_THR_RESERVED);
    // Sub-hundredth rates round to zero in this unit.
    // R5 first-order rate
    ctrl_next.accel1_centi_hz_s = accel_centi(cfg_next[`OLSC_ACC1_HI:`OLSC_ACC1_LO]);
    // R6 unlimited acceleration
    ctrl_next.accel1_unlimited =
      (cfg_next[`OLSC_ACC1_HI:`OLSC_ACC1_LO] == `OLSC_ACC_NO_LIMIT);
    // Only the unlimited flag is decoded; the rate code stays raw in cfg.
    // R8 second-order limit
    ctrl_next.accel2_unlimited =
      (cfg_next[`OLSC_ACC2_HI:`OLSC_ACC2_LO] == `OLSC_ACC_NO_LIMIT);
    // The arithmetic cannot wrap, since the codes stop at 1Fh.
    // R9 handoff frequency
    ctrl_next.handoff_hz = handoff_hz(cfg_next[`OLSC_HOFF_HI:`OLSC_HOFF_LO]);
    // Auto handoff overrides the threshold field in the sequencer.
    // R10 handoff and first cycle
    ctrl_next.auto_handoff = cfg_next[`OLSC_BIT_AUTO_HOFF];
    ctrl_next.first_cycle_zero = cfg_next[`OLSC_BIT_FC_ZERO];
  end

  // Controls are registered so the sequencer sees glitch-free values.
  // Reset values are the decodes of an all-zero register, so ctrl agrees with cfg.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_reg <= '0;
      ctrl_reg.duty_cap_pct <= 7'h0a;
      ctrl_reg.threshold_reserved <= 1'b1;
      ctrl_reg.handoff_hz <= 10'h001;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Bus answers and decoded controls leave straight from their flip-flops.
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign ctrl = ctrl_reg;

  // Raw fields straight from the storage flip-flops.
  // One process drives the whole struct, so no member has a second driver.
  always_comb
  begin
    cfg.parity = cfg_reg[`OLSC_BIT_PARITY];
    cfg.limit_source_sel = cfg_reg[`OLSC_BIT_LIM_SRC];
    cfg.duty_cap = cfg_reg[`OLSC_DUTY_HI:`OLSC_DUTY_LO];
    cfg.threshold_code = cfg_reg[`OLSC_THR_HI:`OLSC_THR_LO];
    cfg.accel_first_order = cfg_reg[`OLSC_ACC1_HI:`OLSC_ACC1_LO];
    cfg.accel_second_order = cfg_reg[`OLSC_ACC2_HI:`OLSC_ACC2_LO];
    cfg.handoff_freq = cfg_reg[`OLSC_HOFF_HI:`OLSC_HOFF_LO];
    cfg.auto_handoff = cfg_reg[`OLSC_BIT_AUTO_HOFF];
    cfg.first_cycle_zero = cfg_reg[`OLSC_BIT_FC_ZERO];
    cfg.min_duty = cfg_reg[`OLSC_MIND_HI:`OLSC_MIND_LO];
  end

endmodule : olsc_startup_cfg
`default_nettype wire

// file: shared/olsc_consts.svh
// Offsets, field positions, masks, reset values and special field codes for the startup config register.
`ifndef OLSC_CONSTS_SVH
`define OLSC_CONSTS_SVH
`define OLSC_ADDR_W 12
`define OLSC_OFF_CFG 12'h084
`define OLSC_BIT_PARITY 31
`define OLSC_BIT_LIM_SRC 30
`define OLSC_DUTY_HI 29
`define OLSC_DUTY_LO 27
`define OLSC_THR_HI 26
`define OLSC_THR_LO 23
`define OLSC_ACC1_HI 22
`define OLSC_ACC1_LO 18
`define OLSC_ACC2_HI 17
`define OLSC_ACC2_LO 13
`define OLSC_HOFF_HI 12
`define OLSC_HOFF_LO 8
`define OLSC_BIT_AUTO_HOFF 7
`define OLSC_BIT_FC_ZERO 6
`define OLSC_MIND_HI 5
`define OLSC_MIND_LO 2
`define OLSC_WR_MASK 32'hffff_fffc
`define OLSC_RST_VAL 32'h0000_0000
`define OLSC_RSVD_READ 2'h0
`define OLSC_ACC_NO_LIMIT 5'h1f
`define OLSC_ACC_MAX_HZ 16'h7fff
`define OLSC_THR_RESERVED 4'h0
`endif

// file: shared/olsc_pkg.sv
// Types shared by the open-loop startup configuration register block.
`default_nettype none
package olsc_pkg;
  typedef enum logic [1:0] {
    OLSC_IDLE = 2'b01,
    OLSC_ACCESS = 2'b10
  } olsc_state_t;
  typedef struct packed {
    logic parity;
    logic limit_source_sel;
    logic [2:0] duty_cap;
    logic [3:0] threshold_code;
    logic [4:0] accel_first_order;
    logic [4:0] accel_second_order;
    logic [4:0] handoff_freq;
    logic auto_handoff;
    logic first_cycle_zero;
    logic [3:0] min_duty;
  } olsc_cfg_t;
  typedef struct packed {
    logic limit_from_general;
    logic [6:0] duty_cap_pct;
    logic [3:0] threshold_tenths_v;
    logic threshold_reserved;
    logic [15:0] accel1_centi_hz_s;
    logic accel1_unlimited;
    logic accel2_unlimited;
    logic [9:0] handoff_hz;
    logic auto_handoff;
    logic first_cycle_zero;
  } olsc_ctrl_t;
endpackage : olsc_pkg
`default_nettype wire

// file: bench/olsc_startup_cfg_checker.sv
// Port-level assertions for the open-loop startup configuration register.
`default_nettype none
module olsc_startup_cfg_checker (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire olsc_pkg::olsc_cfg_t cfg,
  input wire olsc_pkg::olsc_ctrl_t ctrl
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Answers need a prior access phase and last one cycle.
  a_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  a_err_addr: assert property (pready |-> pslverr == (paddr != 12'h084))
    else $error("pslverr wrong");
  // Full-word writes land whole; nothing else moves the fields.
  a_write_store: assert property (pready && pwrite && !pslverr && pstrb == 4'hf
    |=> cfg == 30'($past(pwdata) >> 2)) else $error("write not stored");
  a_cfg_stable: assert property (!(pready && pwrite && !pslverr) |=> $stable(cfg))
    else $error("cfg changed");
  a_read_data: assert property (pready && !pwrite && !pslverr |-> prdata == {cfg, 2'h0})
    else $error("read data wrong");
  a_duty_full: assert property (cfg.duty_cap == 3'h7 |-> ctrl.duty_cap_pct == 7'd100)
    else $error("duty decode wrong");
  a_thr_rsvd: assert property (ctrl.threshold_reserved == (cfg.threshold_code == 4'h0))
    else $error("threshold flag wrong");
  a_acc_unlim: assert property (ctrl.accel1_unlimited == (cfg.accel_first_order == 5'h1f))
    else $error("accel flag wrong");
  a_src_sel: assert property (ctrl.limit_from_general == cfg.limit_source_sel)
    else $error("limit source wrong");
  c_write: cover property (pready && pwrite && !pslverr);
  c_read: cover property (pready && !pwrite && !pslverr);
  c_refused: cover property (pready && pslverr);
endmodule : olsc_startup_cfg_checker
bind olsc_startup_cfg olsc_startup_cfg_checker u_chk (.clk_sys(clk_sys), .rstn(rstn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cfg(cfg), .ctrl(ctrl));
`default_nettype wire

// file: bench/olsc_startup_cfg_test.sv
// Self-checking bench for the open-loop startup configuration register.
`default_nettype none
module olsc_startup_cfg_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] pstrb = 4'h0;
  olsc_pkg::olsc_cfg_t cfg;
  olsc_pkg::olsc_ctrl_t ctrl;
  int error_cnt = 0;
  int compares = 0;
  logic [6:0] duty_tab [8] = '{7'd10, 7'd15, 7'd20, 7'd25, 7'd30, 7'd40, 7'd50, 7'd100};
  logic [4:0] code_tab [3] = '{5'h00, 5'h07, 5'h1e};
  logic [15:0] acc_tab [3] = '{16'h0000, 16'h0064, 16'hffff};
  logic [9:0] hz_tab [3] = '{10'd1, 10'd28, 10'd550};

  olsc_startup_cfg dut (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cfg(cfg), .ctrl(ctrl));

  // Free-running system clock.
  initial forever #2.5 clk_sys = ~clk_sys;

  task automatic wrap_up();
    if (error_cnt == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer, held until pready is sampled; the wait is bounded.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s, input logic [31:0] exp);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (int n = 0; n < 16 && pready !== 1'b1; n++)
      @(posedge clk_sys);
    if (pready !== 1'b1)
    begin
      error_cnt++;
      wrap_up();
    end
    chk(32'(pslverr), 32'(a != 12'h084));
    if (!w)
      chk(prdata, exp);
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : xfer

  initial
  begin
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    #1;
    chk(32'(cfg), 32'h0);
    chk(32'(ctrl.duty_cap_pct), 32'd10);
    xfer(1'b0, 12'h084, 32'h0, 4'h0, 32'h0);
    xfer(1'b1, 12'h084, 32'hffff_ffff, 4'hf, 32'h0);
    xfer(1'b0, 12'h084, 32'h0, 4'h0, 32'hffff_fffc);
    chk(32'({ctrl.limit_from_general, ctrl.accel2_unlimited}), 32'h3);
    chk(32'({ctrl.accel1_unlimited, ctrl.accel1_centi_hz_s}), 32'h1_ffff);
    chk(32'({ctrl.auto_handoff, ctrl.first_cycle_zero}), 32'h3);
    chk(32'(ctrl.handoff_hz), 32'd600);
    // A narrow strobe and a refused address must leave other bytes alone.
    xfer(1'b1, 12'h084, 32'h0, 4'h1, 32'h0);
    xfer(1'b1, 12'h088, 32'h0, 4'hf, 32'h0);
    xfer(1'b0, 12'h088, 32'h0, 4'h0, 32'h0);
    xfer(1'b0, 12'h084, 32'h0, 4'h0, 32'hffff_ff00);
    for (int i = 0; i < 16; i++)
    begin
      xfer(1'b1, 12'h084, {2'h0, i[2:0], i[3:0], 23'h0}, 4'hf, 32'h0);
      chk(32'(ctrl.duty_cap_pct), 32'(duty_tab[i[2:0]]));
      chk(32'({ctrl.threshold_reserved, ctrl.threshold_tenths_v}), {27'h0, i == 0, i[3:0]});
    end
    for (int k = 0; k < 3; k++)
    begin
      xfer(1'b1, 12'h084, {9'h0, {3{code_tab[k]}}, 8'h0}, 4'hf, 32'h0);
      chk(32'(ctrl.accel1_centi_hz_s), 32'(acc_tab[k]));
      chk(32'(ctrl.handoff_hz), 32'(hz_tab[k]));
      chk(32'({ctrl.accel1_unlimited, ctrl.accel2_unlimited}), 32'h0);
    end
    // A reset in mid-run must bring a written register back to zero.
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    #1;
    chk(32'(cfg), 32'h0);
    chk(32'({ctrl.threshold_reserved, ctrl.handoff_hz}), 32'h401);
    xfer(1'b0, 12'h084, 32'h0, 4'h0, 32'h0);
    wrap_up();
  end
endmodule : olsc_startup_cfg_test
`default_nettype wire
